// File: bench/lcc_logic_cell_row_tb.sv
// Self-checking bench for the logic cell row.
module lcc_logic_cell_row_tb
  import lcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // Clock and reset, reset held from time zero.
  logic ref_clk = 1'h0;
  logic sys_rst = 1'h1;
  // Row inputs, all quiet at time zero.
  lcc_cell_cfg_t [LCC_TOTAL-1:0] cellCfg = '0;
  lcc_operands_t [LCC_TOTAL-1:0] cellOperands = '0;
  logic [LCC_CLUSTERS-1:0] clusterCtrlEn = '0;
  logic [LCC_CLUSTERS-1:0] chainCarryIn = '0;
  // Row outputs.
  logic [LCC_TOTAL-1:0] cellOut_q;
  logic [LCC_CLUSTERS-1:0] clusterCarryOut_q;
  logic [LCC_CLUSTERS-1:0] clusterCascadeOut_q;
  // Counters for the verdict and the hang guard.
  int numErrors = 0;
  int testsRun = 0;
  int cycles = 0;
  // Adder operands and the expected carry and sum.
  logic [7:0] a;
  logic [7:0] b;
  logic ci;
  logic [8:0] sumExp;
  // Table rows: mask, operands {D,C,B,A}, expected output.
  logic [20:0] lutRows [10] = '{{16'hFFFF, 4'h0, 1'h1},
    {16'h0000, 4'hF, 1'h0}, {16'h8000, 4'hF, 1'h1}, {16'h8000, 4'hE, 1'h0},
    {16'h0001, 4'h0, 1'h1}, {16'h0002, 4'h1, 1'h1}, {16'h0004, 4'h2, 1'h1},
    {16'h0010, 4'h4, 1'h1}, {16'h0100, 4'h8, 1'h1}, {16'h6996, 4'h5, 1'h0}};
  // Adder rows: a, b, carry into the chain.
  logic [16:0] addRows [2] = '{{8'hAB, 8'h55, 1'h1}, {8'h00, 8'hFF, 1'h0}};
  // Control rows: enable, first cell operands, stage operands, expected.
  logic [9:0] ctlRows [5] = '{{1'h1, 4'h0, 4'h8, 1'h0},
    {1'h1, 4'h2, 4'h8, 1'h1}, {1'h1, 4'h1, 4'h0, 1'h0},
    {1'h1, 4'h3, 4'h8, 1'h0}, {1'h0, 4'h1, 4'h0, 1'h1}};

  // The 8 ns clock.
  always #4 ref_clk = ~ref_clk;

  lcc_logic_cell_row u_lcc_logic_cell_row (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .cellCfg(cellCfg),
    .cellOperands(cellOperands),
    .clusterCtrlEn(clusterCtrlEn),
    .chainCarryIn(chainCarryIn),
    .cellOut_q(cellOut_q),
    .clusterCarryOut_q(clusterCarryOut_q),
    .clusterCascadeOut_q(clusterCascadeOut_q)
  );

  // Prints the counts and the verdict, then stops the run.
  task automatic closeOut();
    $display("Checks %0d, mismatches %0d", testsRun, numErrors);
    if (numErrors == 0 && testsRun > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Compares with case equality so an unknown never matches.
  task automatic chk(logic [219:0] seen, logic [219:0] exp);
    testsRun++;
    if (seen !== exp)
    begin
      numErrors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Sets one cell; called just after a rising edge.
  task automatic setCell(int i, logic [15:0] m, logic ar, logic cu,
                         logic rg, logic ca, logic [3:0] op);
    cellCfg[i] <= lcc_cell_cfg_t'({m, ar, ca, cu, rg});
    cellOperands[i] <= op;
  endtask

  // Lets n edges pass, then steps off the edge to sample.
  task automatic wt(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // Cuts a hung run short well past the expected length.
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 1000)
    begin
      numErrors++;
      closeOut();
    end
  end

  initial
  begin
    // Cell 0 would show a one if reset did not hold it.
    cellCfg[0] <= lcc_cell_cfg_t'({16'hFFFF, 4'h0});
    wt(4);
    chk(cellOut_q, '0);
    @(posedge ref_clk);
    sys_rst <= 1'h0;
    wt(2);
    chk(cellOut_q[0], 1'h1);
    $display("Test reset done");
    foreach (lutRows[r])
    begin
      @(posedge ref_clk);
      setCell(75, lutRows[r][20:5], 1'h0, 1'h0, 1'h0, 1'h0, lutRows[r][4:1]);
      wt(1);
      chk(cellOut_q[75], lutRows[r][0]);
    end
    $display("Test table done");
    // Eight-bit adder in cluster 0, spare cell 9 shows the last carry.
    foreach (addRows[r])
    begin
      {a, b, ci} = addRows[r];
      sumExp = a + b + ci;
      @(posedge ref_clk);
      chainCarryIn <= {19'h0, 1'h1, 1'h0, ci};
      for (int k = 1; k < 9; k++)
        setCell(k, 16'hE896, 1'h1, 1'h0, 1'h0, 1'h0, {2'h0, b[k-1], a[k-1]});
      setCell(9, 16'hF0F0, 1'h1, 1'h0, 1'h0, 1'h0, 4'h0);
      setCell(10, 16'h00F0, 1'h1, 1'h0, 1'h0, 1'h0, 4'h0);
      setCell(11, 16'hE896, 1'h1, 1'h0, 1'h0, 1'h0, 4'h0);
      setCell(21, 16'hE896, 1'h1, 1'h0, 1'h0, 1'h0, 4'h0);
      setCell(111, 16'hE896, 1'h1, 1'h0, 1'h0, 1'h0, 4'h0);
      // Cluster 9 always carries out, two clusters below the row middle.
      for (int k = 91; k < 100; k++)
        setCell(k, 16'hFF00, 1'h1, 1'h0, 1'h0, 1'h0, 4'h0);
      wt(1);
      chk(cellOut_q[9:1], sumExp);
      chk(clusterCarryOut_q[0], sumExp[8]);
      chk(cellOut_q[21], sumExp[8]);
      chk(cellOut_q[11], 1'h0);
      chk(cellOut_q[10], 1'h0);
      chk({clusterCarryOut_q[9], cellOut_q[111]}, 2'h2);
    end
    $display("Test adder done");
    @(posedge ref_clk);
    for (int k = 30; k < 40; k++)
      setCell(k, k == 39 ? 16'h00FF : 16'hFFFF, k == 39, 1'h1, 1'h0, 1'h0,
              4'h0);
    setCell(49, 16'hFFFF, 1'h0, 1'h0, 1'h0, 1'h0, 4'h0);
    wt(1);
    chk(clusterCascadeOut_q[4:3], 2'h3);
    @(posedge ref_clk);
    setCell(34, 16'h0000, 1'h0, 1'h1, 1'h0, 1'h0, 4'h0);
    setCell(49, 16'hFFFF, 1'h0, 1'h1, 1'h0, 1'h0, 4'h0);
    wt(1);
    chk(clusterCascadeOut_q[4:3], 2'h0);
    $display("Test cascade done");
    @(posedge ref_clk);
    setCell(85, 16'h0002, 1'h0, 1'h0, 1'h1, 1'h0, 4'h1);
    wt(1);
    chk(cellOut_q[85], 1'h0);
    wt(1);
    chk(cellOut_q[85], 1'h1);
    $display("Test register done");
    foreach (ctlRows[r])
    begin
      @(posedge ref_clk);
      clusterCtrlEn[5] <= ctlRows[r][9];
      setCell(50, 16'h0000, 1'h0, 1'h0, 1'h0, 1'h0, ctlRows[r][8:5]);
      setCell(51, 16'h00FF, 1'h0, 1'h0, 1'h1, 1'h0, ctlRows[r][4:1]);
      wt(2);
      chk(cellOut_q[51], ctlRows[r][0]);
    end
    $display("Test control done");
    // Cell 61 always carries, so cell 62 sees a one only by substitution.
    for (int c = 0; c < 2; c++)
    begin
      @(posedge ref_clk);
      setCell(61, 16'hFF00, 1'h1, 1'h0, 1'h0, 1'h0, 4'h0);
      setCell(62, 16'h00F0, 1'h0, 1'h0, 1'h0, c[0], 4'h0);
      wt(1);
      chk(cellOut_q[62], c[0]);
    end
    $display("Test substitution done");
    closeOut();
  end
endmodule

// File: rtl/lcc_logic_cell_row.sv
// What this block does
// - Four-input table then a programmable flip-flop.
// - Carry-in feeds table and next carry stage.
// - First cell of a cluster never chains.
// - First cell inputs make clear and load.
// - Chains beyond nine cells link clusters.
// - Chains skip a cluster, keeping even or odd parity.
// - Chains never cross the middle of row.
// - n-bit adder uses n plus one cells.
// - Sum leaves directly or through the flip-flop.
// - Normal mode may swap carry-in for third.
// - Table result combines with cascade-in outward.
// - Arithmetic mode splits into two three-input tables.
// - Adder table outputs a plus b plus carry.
// - Second table makes carry-out from same signals.
// - Cascade chain works alongside arithmetic mode.
module lcc_logic_cell_row
  import lcc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire lcc_cell_cfg_t [LCC_TOTAL-1:0] cellCfg,
  input wire lcc_operands_t [LCC_TOTAL-1:0] cellOperands,
  input wire logic [LCC_CLUSTERS-1:0] clusterCtrlEn,
  input wire logic [LCC_CLUSTERS-1:0] chainCarryIn,
  output logic [LCC_TOTAL-1:0] cellOut_q,
  output logic [LCC_CLUSTERS-1:0] clusterCarryOut_q,
  output logic [LCC_CLUSTERS-1:0] clusterCascadeOut_q
);

  // Selects one entry of a lookup mask; shared by both table widths.
  function automatic logic lutPick(input logic [15:0] mask,
                                   input logic [3:0] sel);
    lutPick = mask[sel];
  endfunction

  // Carry arriving at each cell.
  logic [LCC_TOTAL-1:0] carryIn;
  // Carry leaving each cell toward the higher-order bit.
  logic [LCC_TOTAL-1:0] carryOut;
  // Cascade arriving at each cell, after the idle substitution.
  logic [LCC_TOTAL-1:0] cascIn;
  // Cascade leaving each cell; also the cell's combined result.
  logic [LCC_TOTAL-1:0] cellRes;
  // Raw table result before the cascade gate.
  logic [LCC_TOTAL-1:0] lutRes;
  // Cluster wide synchronous clear and load.
  logic [LCC_CLUSTERS-1:0] syncClr;
  logic [LCC_CLUSTERS-1:0] syncLoad;
  // Cell flip-flops and their next values.
  logic [LCC_TOTAL-1:0] cellFf_q;
  logic [LCC_TOTAL-1:0] cellFf_d;
  // Next values of the registered outputs.
  logic [LCC_TOTAL-1:0] cellOut_d;
  logic [LCC_CLUSTERS-1:0] clusterCarryOut_d;
  logic [LCC_CLUSTERS-1:0] clusterCascadeOut_d;

  // Cluster controls come from the first cell's operands when enabled.
  always_comb
  begin
    for (int j = 0; j < LCC_CLUSTERS; j++)
    begin
      // Operand a clears, operand b loads, only when enabled.
      syncClr[j] = clusterCtrlEn[j] &
                   cellOperands[j*LCC_CELLS].operandA;
      syncLoad[j] = clusterCtrlEn[j] &
                    cellOperands[j*LCC_CELLS].operandB;
    end
  end

  // Cell datapath, walked from the low cluster upward so that every
  // carry is computed before the cell that consumes it.
  always_comb
  begin
    int idx;
    int src;
    lcc_operands_t op;
    lcc_cell_cfg_t cfg;
    logic thirdIn;
    idx = 0;
    src = 0;
    op = '0;
    cfg = '0;
    thirdIn = 1'b0;
    carryIn = '0;
    carryOut = '0;
    cascIn = '0;
    cellRes = '0;
    lutRes = '0;
    for (int j = 0; j < LCC_CLUSTERS; j++)
    begin
      for (int k = 0; k < LCC_CELLS; k++)
      begin
        idx = j * LCC_CELLS + k;
        op = cellOperands[idx];
        cfg = cellCfg[idx];
        // Carry source depends on the cell's place in the chain.
        if (k == 0)
        begin
          // The control-capable cell is kept out of every carry chain.
          carryIn[idx] = 1'b0;
        end
        else if (k > 1)
        begin
          // Inside a cluster the carry steps to the next cell.
          carryIn[idx] = carryOut[idx-1];
        end
        else if ((j % LCC_HALF) >= LCC_SKIP)
        begin
          // Long chains continue two clusters up, same parity.
          src = (j - LCC_SKIP) * LCC_CELLS + LCC_LAST;
          carryIn[idx] = carryOut[src];
        end
        else
        begin
          // A fresh chain starts at each half row's first clusters.
          carryIn[idx] = chainCarryIn[j];
        end
        // Unused cascade path reads as the idle level.
        if (!cfg.cascadeUsed || k == 0)
        begin
          cascIn[idx] = LCC_CASC_IDLE;
        end
        else
        begin
          cascIn[idx] = cellRes[idx-1];
        end
        if (cfg.mode == LCC_ARITH)
        begin
          // Low half computes the result, high half the carry.
          lutRes[idx] = lutPick(cfg.lutMask,
            {1'b0, carryIn[idx], op.operandB, op.operandA});
          carryOut[idx] = lutPick(cfg.lutMask,
            {1'b1, carryIn[idx], op.operandB,
             op.operandA});
        end
        else
        begin
          // Third input may be replaced by the incoming carry.
          thirdIn = cfg.carryAsC ? carryIn[idx] : op.operandC;
          lutRes[idx] = lutPick(cfg.lutMask,
            {op.operandD, thirdIn, op.operandB, op.operandA});
          carryOut[idx] = 1'b0;
        end
        // The cascade gate applies in both modes.
        cellRes[idx] = lutRes[idx] & cascIn[idx];
      end
    end
  end

  // Next state of flip-flops and outputs.
  always_comb
  begin
    int cl;
    cl = 0;
    for (int i = 0; i < LCC_TOTAL; i++)
    begin
      cl = i / LCC_CELLS;
      // Clear beats load, and both override the cascade result.
      if (syncClr[cl])
      begin
        cellFf_d[i] = LCC_RST_VAL;
      end
      else if (syncLoad[cl])
      begin
        cellFf_d[i] = cellOperands[i].operandD;
      end
      else
      begin
        cellFf_d[i] = cellRes[i];
      end
      // Output comes straight from the logic or from the flip-flop.
      cellOut_d[i] = cellCfg[i].registered ? cellFf_q[i]
                                           : cellRes[i];
    end
    for (int j = 0; j < LCC_CLUSTERS; j++)
    begin
      // The last carry is shown so a spare cell can route it out.
      clusterCarryOut_d[j] =
        carryOut[j*LCC_CELLS+LCC_LAST];
      clusterCascadeOut_d[j] = cellRes[j*LCC_CELLS+LCC_LAST];
    end
  end

  // Registers only.
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      cellFf_q <= {LCC_TOTAL{LCC_RST_VAL}};
      cellOut_q <= {LCC_TOTAL{LCC_RST_VAL}};
      clusterCarryOut_q <= {LCC_CLUSTERS{LCC_RST_VAL}};
      clusterCascadeOut_q <= {LCC_CLUSTERS{LCC_RST_VAL}};
    end
    else
    begin
      cellFf_q <= cellFf_d;
      cellOut_q <= cellOut_d;
      clusterCarryOut_q <= clusterCarryOut_d;
      clusterCascadeOut_q <= clusterCascadeOut_d;
    end
  end

  // Cells and the cluster that the bench drives, watched below.
  localparam int C21 = 2 * LCC_CELLS + 1;
  localparam int C09 = LCC_LAST;
  localparam int C111 = LCC_HALF * LCC_CELLS + 1;
  localparam int C5 = 5;
  localparam int CLU5 = 5;
  localparam int C51 = CLU5 * LCC_CELLS + 1;
  localparam int C35 = 3 * LCC_CELLS + 5;
  localparam int C62 = 6 * LCC_CELLS + 2;
  localparam int C85 = 8 * LCC_CELLS + 5;

  // A bypassed cell shows its result on the next edge.
  sequence sBypassSet;
    !cellCfg[C5].registered;
  endsequence
  // A load that no clear overrides, seen on the watched cluster.
  sequence sLoadOnly;
    syncLoad[CLU5] && !syncClr[CLU5];
  endsequence
  // The watched accumulator keeps its flip-flop in the output path.
  sequence sAccumHeld;
    cellCfg[C51].registered;
  endsequence

  // Cluster two takes the carry of cluster zero's last cell.
  AST_CARRY_SKIP: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    carryIn[C21] == carryOut[C09])
    else $error("Carry did not skip to the cluster two up.");

  // The first cluster of the upper half starts a fresh chain.
  AST_HALF_ROW: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    carryIn[C111] == chainCarryIn[LCC_HALF])
    else $error("Carry crossed the middle of the row.");

  // A first cell whose table passes on its carry must show a zero.
  AST_FIRST_CELL: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (cellCfg[LCC_CELLS].mode == LCC_ARITH &&
     cellCfg[LCC_CELLS].lutMask[7:0] == 8'hF0) |->
    lutRes[LCC_CELLS] == 1'b0)
    else $error("First cell of a cluster received a carry.");

  // The adder mask makes the low half a three-way exclusive or.
  AST_ADD_SUM: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (cellCfg[C5].mode == LCC_ARITH &&
     cellCfg[C5].lutMask[7:0] == LCC_ADD_SUM) |->
    lutRes[C5] == (cellOperands[C5].operandA ^
                   cellOperands[C5].operandB ^ carryIn[C5]))
    else $error("Adder sum is wrong.");

  // The adder mask makes the high half a majority vote.
  AST_ADD_CARRY: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (cellCfg[C5].mode == LCC_ARITH &&
     cellCfg[C5].lutMask[15:8] == LCC_ADD_CARRY) |->
    carryIn[C5+1] == ((cellOperands[C5].operandA &
      cellOperands[C5].operandB) | (carryIn[C5] &
      (cellOperands[C5].operandA | cellOperands[C5].operandB))))
    else $error("Adder carry is wrong.");

  // A bypassed output follows the combined result one edge later.
  AST_BYPASS: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    sBypassSet ##0 !sys_rst ##1 1'b1 |->
    cellOut_q[C5] == $past(cellRes[C5]))
    else $error("Bypassed output did not follow the result.");

  // An unused cascade leaves the table result untouched.
  AST_CASC_IDLE: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    !cellCfg[C5].cascadeUsed |-> cellRes[C5] == lutRes[C5])
    else $error("Unused cascade altered the result.");

  // A clear empties the accumulator of its cluster.
  AST_SYNC_CLR: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    syncClr[CLU5] ##1 sAccumHeld [*2] |->
    cellOut_q[C51] == LCC_RST_VAL)
    else $error("Synchronous clear did not empty the accumulator.");

  // With the swap set the third table input is the carry.
  AST_CARRY_AS_C: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (cellCfg[C62].mode == LCC_NORMAL && cellCfg[C62].carryAsC) |->
    lutRes[C62] == cellCfg[C62].lutMask[{cellOperands[C62].operandD,
      carryIn[C62], cellOperands[C62].operandB,
      cellOperands[C62].operandA}])
    else $error("Normal mode did not use the carry as third input.");

  // A load reaches the registered output two edges later.
  AST_LOAD_D: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    sLoadOnly ##1 sAccumHeld ##1 1'b1 |->
    cellOut_q[C51] == $past(cellOperands[C51].operandD, 2))
    else $error("Synchronous load did not reach the accumulator.");

  // With clear and load together the flip-flops take the clear.
  AST_CLR_BEATS_LOAD: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (syncClr[CLU5] && syncLoad[CLU5]) |=>
    cellFf_q[C51] == LCC_RST_VAL)
    else $error("Synchronous load overrode the clear.");

  // A registered cell shows its flip-flop one edge later.
  AST_REG_OUT: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    cellCfg[C85].registered |=>
    cellOut_q[C85] == $past(cellFf_q[C85]))
    else $error("Registered output did not follow the flip-flop.");

  // A used cascade ands the table result with the cell below.
  AST_CASC_AND: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    cellCfg[C35].cascadeUsed |->
    cellRes[C35] == (lutRes[C35] & cellRes[C35-1]))
    else $error("Cascade gate did not form an and.");

  // A pass-through mask sends the carry out of both table halves.
  AST_ARITH_SPLIT: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (cellCfg[C09].mode == LCC_ARITH &&
     cellCfg[C09].lutMask == 16'hF0F0) |->
    (lutRes[C09] == carryIn[C09] && carryOut[C09] == carryIn[C09]))
    else $error("Arithmetic halves did not follow their masks.");
endmodule

// File: rtl/lcc_pkg.sv
// Shared constants and carriers for the logic cell row.
package lcc_pkg;
  // Cells in one cluster, and clusters in one row.
  localparam int LCC_CELLS = 10;
  localparam int LCC_CLUSTERS = 22;
  // Clusters in one half row; chains never cross this boundary.
  localparam int LCC_HALF = 11;
  // Total cells in the row.
  localparam int LCC_TOTAL = LCC_CELLS * LCC_CLUSTERS;
  // Position of the last cell of a cluster.
  localparam int LCC_LAST = LCC_CELLS - 1;
  // A chain jumps this many clusters to keep even and odd apart.
  localparam int LCC_SKIP = 2;
  // Lookup masks that turn an arithmetic cell into a full adder.
  localparam logic [7:0] LCC_ADD_SUM = 8'h96;
  localparam logic [7:0] LCC_ADD_CARRY = 8'hE8;
  // Value of every flip-flop and output after reset.
  localparam logic LCC_RST_VAL = 1'h0;
  // Cascade input level seen when the cascade path is unused.
  localparam logic LCC_CASC_IDLE = 1'h1;

  // Operating mode of one cell.
  typedef enum logic
  {
    LCC_NORMAL = 1'b0,
    LCC_ARITH = 1'b1
  } lcc_mode_t;

  // Configuration of one cell.
  typedef struct packed
  {
    logic [15:0] lutMask;
    lcc_mode_t mode;
    logic carryAsC;
    logic cascadeUsed;
    logic registered;
  } lcc_cell_cfg_t;

  // The four local operands of one cell.
  typedef struct packed
  {
    logic operandD;
    logic operandC;
    logic operandB;
    logic operandA;
  } lcc_operands_t;
endpackage
